/* logic/pmi_command_decoder.sv */
`timescale 1ns/10ps
// What this block does
// - answer write address 9C, take commands
// - start is data falling, clock high
// - stop is data rising, clock high
// - pull data low through acknowledge pulse
// - address plus one command updates group
// - group zero opens output or mask byte
// - output byte switches five supplies, pin mask
// - deep sleep needs both bits set
// - charger suspended while enable bit zero
// - five-bit core voltage code, default eight
// - first aux voltage code, bits two-one
// - second aux voltage code, bits four-three
// - reset released 200 ms after switcher good
// - read address 9D returns status byte
module pmi_command_decoder
  import pmi_pkg::*;
#(
  parameter int unsigned RESET_DELAY_CYCLES = pmi_pkg::PMI_RESET_DELAY_CYCLES
) (
  // core clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link sampling clock
  input wire logic link_clock,
  // serial bus pins
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  // analog and status inputs
  input wire logic core_switcher_good,
  input wire logic [7:0] status_in,
  // supply controls
  output logic precore_linear_reg_en,
  output logic pll_linear_reg_en,
  output logic io_linear_reg_en,
  output logic memory_switcher_en,
  output logic core_switcher_en,
  output logic first_aux_reg_en,
  output logic second_aux_reg_en,
  output logic power_enable_pin_mask,
  output logic [5:0] event_mask,
  // sleep and charger
  output logic deep_sleep_ready,
  output logic deep_sleep_request,
  output logic deep_sleep_enter,
  output logic charger_enable,
  // voltage codes
  output logic [1:0] first_aux_code,
  output logic [1:0] second_aux_code,
  output logic [4:0] voltage_program_code,
  // processor reset
  output logic processor_reset_n
);

  import pmi_pkg::*;

  // --------------------------------------------------------------------------
  // link domain: pin sampling
  // --------------------------------------------------------------------------
  typedef enum {
    pmi_idle,
    pmi_addr,
    pmi_addr_ack,
    pmi_write,
    pmi_write_ack,
    pmi_read,
    pmi_read_ack,
    pmi_skip
  } pmi_state_t;

  logic scl;
  logic sda;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  pmi_state_t state;
  logic [3:0] bit_count;
  logic [7:0] shift;
  logic is_read;
  logic pair_open;
  logic [7:0] cmd_byte;
  pmi_cmd_t cmd_kind;
  logic cmd_toggle;
  logic snap_toggle;
  logic byte_done;
  logic [7:0] status_snap;

  pmi_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_pin_sync (
    .clock(link_clock),
    .reset_n(reset_n),
    .raw({i2c_scl, i2c_sda_in}),
    .filtered({scl, sda})
  );

  // previous filtered levels for edge detection
  always_ff @(posedge link_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  assign start_seen = scl && scl_prev && sda_prev && !sda;
  assign stop_seen = scl && scl_prev && !sda_prev && sda;
  assign scl_rise = scl && !scl_prev;
  assign scl_fall = !scl && scl_prev;
  assign byte_done = (bit_count == PMI_BYTE_BITS);

  // --------------------------------------------------------------------------
  // link domain: bus target state machine
  // --------------------------------------------------------------------------
  // the data line only changes while the clock is low, so a change of the
  // enable can never be mistaken for a start or stop by the master
  always_ff @(posedge link_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= pmi_idle;
      bit_count <= '0;
      shift <= '0;
      is_read <= 1'b0;
      i2c_sda_oe <= 1'b0;
    end
    else if (start_seen)
    begin
      state <= pmi_addr;
      bit_count <= '0;
      i2c_sda_oe <= 1'b0;
    end
    else if (stop_seen)
    begin
      state <= pmi_idle;
      i2c_sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        pmi_addr, pmi_write:
        begin
          if (scl_rise && !byte_done)
          begin
            shift <= {shift[6:0], sda};
            bit_count <= bit_count + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            if (state == pmi_write || shift == PMI_WRITE_ADDR || shift == PMI_READ_ADDR)
            begin
              i2c_sda_oe <= 1'b1;
              state <= (state == pmi_write) ? pmi_write_ack : pmi_addr_ack;
              if (state == pmi_addr)
                is_read <= (shift == PMI_READ_ADDR);
            end
            else
              state <= pmi_skip;
          end
        end
        pmi_addr_ack, pmi_write_ack:
        begin
          // hold low until clock falls again
          if (scl_fall)
          begin
            bit_count <= '0;
            if (is_read)
            begin
              shift <= status_snap;
              i2c_sda_oe <= !status_snap[7];
              state <= pmi_read;
            end
            else
            begin
              i2c_sda_oe <= 1'b0;
              state <= pmi_write;
            end
          end
        end
        pmi_read:
        begin
          if (scl_rise)
            bit_count <= bit_count + 4'h1;
          else if (scl_fall)
          begin
            if (byte_done)
            begin
              // release so the master can answer
              i2c_sda_oe <= 1'b0;
              state <= pmi_read_ack;
            end
            else
            begin
              shift <= {shift[6:0], 1'b0};
              i2c_sda_oe <= !shift[6];
            end
          end
        end
        pmi_read_ack:
        begin
          // a missing acknowledge ends the read, data left high
          if (scl_rise)
          begin
            if (sda)
              state <= pmi_skip;
            else
              state <= pmi_addr_ack;
          end
        end
        pmi_skip:
          i2c_sda_oe <= 1'b0;
        default:
          state <= pmi_idle;
      endcase
    end
  end

  // data pin only ever pulls low
  always_ff @(posedge link_clock or negedge reset_n)
  begin
    if (!reset_n)
      i2c_sda_out <= 1'b0;
    else
      i2c_sda_out <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // link domain: command capture
  // --------------------------------------------------------------------------
  // each acknowledged command byte is handed over
  // group zero waits for its second byte
  // the byte stays stable for a whole byte time, far longer than the crossing
  always_ff @(posedge link_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_byte <= '0;
      cmd_kind <= pmi_cmd_none;
      cmd_toggle <= 1'b0;
      pair_open <= 1'b0;
    end
    else if (start_seen)
      pair_open <= 1'b0;
    else if (state == pmi_write && scl_fall && byte_done)
    begin
      if (pair_open)
      begin
        pair_open <= 1'b0;
        cmd_byte <= shift;
        cmd_toggle <= !cmd_toggle;
        if (shift[PMI_SET_MSB:PMI_SET_LSB] == PMI_SET_OUTPUT)
          cmd_kind <= pmi_cmd_output;
        else if (shift[PMI_SET_MSB:PMI_SET_LSB] == PMI_SET_MASK)
          cmd_kind <= pmi_cmd_mask;
        else
          cmd_kind <= pmi_cmd_none;
      end
      else if (shift[PMI_GROUP_MSB:PMI_GROUP_LSB] == PMI_GROUP_PAIR)
        pair_open <= 1'b1;
      else
      begin
        cmd_byte <= shift;
        cmd_kind <= pmi_cmd_single;
        cmd_toggle <= !cmd_toggle;
      end
    end
  end

  // ask the core for a fresh status snapshot at every start
  always_ff @(posedge link_clock or negedge reset_n)
  begin
    if (!reset_n)
      snap_toggle <= 1'b0;
    else if (start_seen)
      snap_toggle <= !snap_toggle;
  end

  // --------------------------------------------------------------------------
  // core domain: crossings
  // --------------------------------------------------------------------------
  logic cmd_toggle_core;
  logic cmd_toggle_seen;
  logic snap_toggle_core;
  logic snap_toggle_seen;
  logic supply_good;
  logic cmd_event;

  pmi_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h0)
  ) u_core_sync (
    .clock(clock),
    .reset_n(reset_n),
    .raw({cmd_toggle, snap_toggle, core_switcher_good}),
    .filtered({cmd_toggle_core, snap_toggle_core, supply_good})
  );

  // toggle edges mark one event each
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_toggle_seen <= 1'b0;
      snap_toggle_seen <= 1'b0;
    end
    else
    begin
      cmd_toggle_seen <= cmd_toggle_core;
      snap_toggle_seen <= snap_toggle_core;
    end
  end

  assign cmd_event = cmd_toggle_core ^ cmd_toggle_seen;

  // status held still while the link shifts it out
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      status_snap <= '0;
    else if (snap_toggle_core ^ snap_toggle_seen)
      status_snap <= status_in;
  end

  // --------------------------------------------------------------------------
  // core domain: control registers
  // --------------------------------------------------------------------------
  logic [4:0] aux_enable_sleep_ctrl;
  logic [4:0] aux_voltage_charger_ctrl;
  logic [4:0] core_voltage_code;
  logic [5:0] output_enable_ctrl;
  logic [5:0] event_mask_ctrl;
  logic sleeping;

  // charger bit only changes by a write
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_enable_sleep_ctrl <= PMI_AUX_SLEEP_RESET;
      aux_voltage_charger_ctrl <= PMI_AUX_VOLT_RESET;
      core_voltage_code <= PMI_CORE_CODE_RESET;
    end
    else if (cmd_event && cmd_kind == pmi_cmd_single)
    begin
      case (cmd_byte[PMI_GROUP_MSB:PMI_GROUP_LSB])
        PMI_GROUP_AUX_SLEEP:
          aux_enable_sleep_ctrl <= {cmd_byte[4:1], 1'b0};
        PMI_GROUP_AUX_VOLT:
          aux_voltage_charger_ctrl <= cmd_byte[4:0];
        PMI_GROUP_CORE:
          core_voltage_code <= cmd_byte[4:0];
        default:
          core_voltage_code <= core_voltage_code;
      endcase
    end
  end

  // mask set, reserved bit forced to one
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      output_enable_ctrl <= PMI_OUTPUT_EN_RESET;
      event_mask_ctrl <= PMI_EVENT_MASK_RESET;
    end
    else if (cmd_event && cmd_kind == pmi_cmd_output)
      output_enable_ctrl <= cmd_byte[5:0];
    else if (cmd_event && cmd_kind == pmi_cmd_mask)
    begin
      event_mask_ctrl <= cmd_byte[5:0];
      event_mask_ctrl[PMI_MASK_RESERVED_BIT] <= 1'b1;
    end
  end

  assign sleeping = aux_enable_sleep_ctrl[2] && aux_enable_sleep_ctrl[1];

  // --------------------------------------------------------------------------
  // core domain: registered outputs
  // --------------------------------------------------------------------------
  // in deep sleep only the memory switcher stays on
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      precore_linear_reg_en <= PMI_OUTPUT_EN_RESET[5];
      pll_linear_reg_en <= PMI_OUTPUT_EN_RESET[4];
      io_linear_reg_en <= PMI_OUTPUT_EN_RESET[3];
      memory_switcher_en <= PMI_OUTPUT_EN_RESET[2];
      core_switcher_en <= PMI_OUTPUT_EN_RESET[1];
      power_enable_pin_mask <= PMI_OUTPUT_EN_RESET[0];
      first_aux_reg_en <= PMI_AUX_SLEEP_RESET[3];
      second_aux_reg_en <= PMI_AUX_SLEEP_RESET[4];
      deep_sleep_enter <= 1'b0;
    end
    else
    begin
      precore_linear_reg_en <= output_enable_ctrl[5] && !sleeping;
      pll_linear_reg_en <= output_enable_ctrl[4] && !sleeping;
      io_linear_reg_en <= output_enable_ctrl[3] && !sleeping;
      memory_switcher_en <= output_enable_ctrl[2];
      core_switcher_en <= output_enable_ctrl[1] && !sleeping;
      power_enable_pin_mask <= output_enable_ctrl[0];
      first_aux_reg_en <= aux_enable_sleep_ctrl[3] && !sleeping;
      second_aux_reg_en <= aux_enable_sleep_ctrl[4] && !sleeping;
      deep_sleep_enter <= sleeping;
    end
  end

  // plain copies of the stored fields
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      event_mask <= PMI_EVENT_MASK_RESET;
      deep_sleep_ready <= 1'b0;
      deep_sleep_request <= 1'b0;
      charger_enable <= PMI_AUX_VOLT_RESET[0];
      first_aux_code <= PMI_AUX_VOLT_RESET[2:1];
      second_aux_code <= PMI_AUX_VOLT_RESET[4:3];
      voltage_program_code <= PMI_CORE_CODE_RESET;
    end
    else
    begin
      event_mask <= event_mask_ctrl;
      deep_sleep_ready <= aux_enable_sleep_ctrl[2];
      deep_sleep_request <= aux_enable_sleep_ctrl[1];
      charger_enable <= aux_voltage_charger_ctrl[0];
      first_aux_code <= aux_voltage_charger_ctrl[2:1];
      second_aux_code <= aux_voltage_charger_ctrl[4:3];
      voltage_program_code <= core_voltage_code;
    end
  end

  // reset release timer, held low in deep sleep
  pmi_reset_timer #(
    .DELAY_CYCLES(RESET_DELAY_CYCLES)
  ) u_reset_timer (
    .clock(clock),
    .reset_n(reset_n),
    .supply_good(supply_good),
    .hold(deep_sleep_enter),
    .release_n(processor_reset_n)
  );

endmodule : pmi_command_decoder

/* logic/pmi_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants of the power-management command decoder
// ----------------------------------------------------------------------------
package pmi_pkg;

  // bus addresses, already shifted with the direction bit in bit 0
  localparam logic [7:0] PMI_WRITE_ADDR = 8'h9c;
  localparam logic [7:0] PMI_READ_ADDR = 8'h9d;

  // field positions inside a command byte
  localparam int PMI_GROUP_MSB = 7;
  localparam int PMI_GROUP_LSB = 5;
  localparam int PMI_SET_MSB = 7;
  localparam int PMI_SET_LSB = 6;

  // group codes carried in the top three bits
  localparam logic [2:0] PMI_GROUP_PAIR = 3'h0;
  localparam logic [2:0] PMI_GROUP_AUX_SLEEP = 3'h1;
  localparam logic [2:0] PMI_GROUP_AUX_VOLT = 3'h2;
  localparam logic [2:0] PMI_GROUP_CORE = 3'h3;

  // set codes in the top two bits of the second byte of a pair
  localparam logic [1:0] PMI_SET_OUTPUT = 2'h1;
  localparam logic [1:0] PMI_SET_MASK = 2'h2;

  // values after reset
  localparam logic [4:0] PMI_AUX_SLEEP_RESET = 5'h18;
  localparam logic [4:0] PMI_AUX_VOLT_RESET = 5'h1b;
  localparam logic [4:0] PMI_CORE_CODE_RESET = 5'h08;
  localparam logic [5:0] PMI_OUTPUT_EN_RESET = 6'h3e;
  localparam logic [5:0] PMI_EVENT_MASK_RESET = 6'h04;
  localparam int PMI_MASK_RESERVED_BIT = 2;

  // bits in a byte and the width of the bit counter
  localparam logic [3:0] PMI_BYTE_BITS = 4'h8;

  // release delay of the processor reset
  localparam int unsigned PMI_CLOCK_HZ = 100_000_000;
  localparam int unsigned PMI_RESET_DELAY_MS = 200;
  localparam int unsigned PMI_RESET_DELAY_CYCLES = PMI_RESET_DELAY_MS * (PMI_CLOCK_HZ / 1000);

  // kind of a decoded command handed from the link to the core
  typedef enum logic [1:0] {
    pmi_cmd_single,
    pmi_cmd_output,
    pmi_cmd_mask,
    pmi_cmd_none
  } pmi_cmd_t;

endpackage : pmi_pkg

/* logic/pmi_reset_timer.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// processor reset release timer
// ----------------------------------------------------------------------------
module pmi_reset_timer #(
  parameter int unsigned DELAY_CYCLES = 20_000_000,
  parameter int CW = $clog2(DELAY_CYCLES + 1)
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // core switcher good level and forced hold
  input wire logic supply_good,
  input wire logic hold,
  // active-low reset to the processor
  output logic release_n
);

  localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

  logic [CW-1:0] count;

  // count then release
  // a dip of the supply restarts the full delay, never a partial one
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      release_n <= 1'b0;
    end
    else if (!supply_good || hold)
    begin
      count <= '0;
      release_n <= 1'b0;
    end
    else if (count == LAST)
      release_n <= 1'b1;
    else
      count <= count + CW'(1);
  end

endmodule : pmi_reset_timer

/* logic/pmi_sync.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// three-stage synchroniser with agreement filter
// ----------------------------------------------------------------------------
module pmi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset of the receiving domain
  input wire logic clock,
  input wire logic reset_n,
  // raw input and filtered output
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] filtered
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds only stage2, so metastability never reaches logic
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end
    else
    begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the later two stages agree
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      filtered <= RESET_VAL;
    else if (stage2 == stage3)
      filtered <= stage3;
  end

endmodule : pmi_sync

/* tb/pmi_decoder_monitor.sv */
`timescale 1ns/10ps
// ----------------------------------------
// port checker of the command decoder
// ----------------------------------------
module pmi_decoder_monitor
  import pmi_pkg::*;
#(
  parameter int unsigned RESET_DELAY_CYCLES = 50
) (
  // clocks and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic link_clock,
  // bus pins
  input wire logic i2c_scl,
  input wire logic i2c_sda_out,
  input wire logic i2c_sda_oe,
  // supplies, sleep and reset
  input wire logic core_switcher_good,
  input wire logic precore_linear_reg_en,
  input wire logic core_switcher_en,
  input wire logic [5:0] event_mask,
  input wire logic deep_sleep_ready,
  input wire logic deep_sleep_request,
  input wire logic deep_sleep_enter,
  input wire logic processor_reset_n
);
  int unsigned good_cnt;

  // good cycles outside deep sleep; saturates so the count stays small
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      good_cnt <= 0;
    else if (!core_switcher_good || deep_sleep_enter)
      good_cnt <= 0;
    else if (good_cnt < RESET_DELAY_CYCLES + 16)
      good_cnt <= good_cnt + 1;
  end

  a_sda_never_high: assert property (@(posedge link_clock) disable iff (!reset_n)
    !i2c_sda_out) else $error("data pin driven high");
  a_ack_held_high: assert property (@(posedge link_clock) disable iff (!reset_n)
    i2c_scl && $past(i2c_scl) |-> $stable(i2c_sda_oe)) else $error("data moved in clock high");
  a_sleep_needs_both: assert property (@(posedge clock) disable iff (!reset_n)
    !(deep_sleep_ready && deep_sleep_request) ##1 !(deep_sleep_ready && deep_sleep_request)
    |-> !deep_sleep_enter) else $error("sleep with one bit");
  a_sleep_both_enter: assert property (@(posedge clock) disable iff (!reset_n)
    (deep_sleep_ready && deep_sleep_request) [*2] |-> deep_sleep_enter)
    else $error("sleep not entered");
  a_sleep_supplies_off: assert property (@(posedge clock) disable iff (!reset_n)
    deep_sleep_enter [*3] |-> !core_switcher_en && !precore_linear_reg_en)
    else $error("supply on in sleep");
  a_sleep_holds_reset: assert property (@(posedge clock) disable iff (!reset_n)
    deep_sleep_enter [*3] |-> !processor_reset_n) else $error("reset high in sleep");
  a_reset_not_early: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(processor_reset_n) |-> good_cnt >= RESET_DELAY_CYCLES) else $error("reset early");
  a_reset_not_late: assert property (@(posedge clock) disable iff (!reset_n)
    good_cnt >= RESET_DELAY_CYCLES + 12 |-> processor_reset_n) else $error("reset late");
  a_reset_drop: assert property (@(posedge clock) disable iff (!reset_n)
    !core_switcher_good [*6] |-> !processor_reset_n) else $error("reset kept high");
  a_mask_reserved_set: assert property (@(posedge clock) disable iff (!reset_n)
    event_mask[PMI_MASK_RESERVED_BIT]) else $error("reserved mask bit clear");
endmodule : pmi_decoder_monitor

bind pmi_command_decoder pmi_decoder_monitor #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) u_mon (
  .clock, .reset_n, .link_clock, .i2c_scl, .i2c_sda_out, .i2c_sda_oe, .core_switcher_good,
  .precore_linear_reg_en, .core_switcher_en, .event_mask, .deep_sleep_ready,
  .deep_sleep_request, .deep_sleep_enter, .processor_reset_n);

/* tb/pmi_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// bus master standing in for the host
// ----------------------------------------
module pmi_host_model (
  // open-drain bus; a released data line reads the pull-up
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  localparam int Q = 300;

  // idle bus: both lines high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task start_c();
    sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_c

  // one bit; the line is sampled early and late in the high phase
  task bit_c(input logic b, output logic s1, output logic s2);
    sda_drv = b;
    #Q scl = 1'b1;
    #20 s1 = sda_line;
    #(2*Q-40) s2 = sda_line;
    #20 scl = 1'b0;
    #Q;
  endtask : bit_c

  // acked only if the line is low at both the early and the late sample of the high phase
  task send_byte(input logic [7:0] b, output logic acked);
    logic s1, s2;
    for (int i = 7; i >= 0; i--)
      bit_c(b[i], s1, s2);
    bit_c(1'b1, s1, s2);
    acked = !s1 && !s2;
  endtask : send_byte

  task read_byte(input logic last, output logic [7:0] b);
    logic s1, s2;
    for (int i = 7; i >= 0; i--)
    begin
      bit_c(1'b1, s1, s2);
      b[i] = s1;
    end
    bit_c(last, s1, s2);
  endtask : read_byte

  task stop_c();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop_c
endmodule : pmi_host_model

/* tb/pmic_i2c_command_decoder_bench.sv */
`timescale 1ns/10ps
// ----------------------------------------
// self-checking bench of the command decoder
// ----------------------------------------
module pmic_i2c_command_decoder_bench;
  import pmi_pkg::*;
  localparam int unsigned DELAY = 50;
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic reset_n = 1'b0;
  logic core_switcher_good = 1'b0;
  logic [7:0] status_in = 8'h00;
  logic i2c_scl, sda_drv, i2c_sda_out, i2c_sda_oe, sda_line;
  logic precore_linear_reg_en, pll_linear_reg_en, io_linear_reg_en, memory_switcher_en;
  logic core_switcher_en, first_aux_reg_en, second_aux_reg_en, power_enable_pin_mask;
  logic deep_sleep_ready, deep_sleep_request, deep_sleep_enter, charger_enable;
  logic [5:0] event_mask;
  logic [1:0] first_aux_code, second_aux_code, v;
  logic [4:0] voltage_program_code;
  logic processor_reset_n, a0, a1;
  logic [7:0] rd;
  logic [4:0] codes [4] = '{5'h1f, 5'h10, 5'h0f, 5'h08};
  logic [4:0] sleeps [4] = '{5'h1c, 5'h1a, 5'h1e, 5'h1c};
  logic [5:0] masks [2] = '{6'h3b, 6'h00};
  int num_errors = 0;
  int checks_done = 0;

  // link clock offset so its edges never line up with the core clock
  always #5 clock = ~clock;
  initial
  begin
    #7;
    forever #15 link_clock = ~link_clock;
  end

  // wired-and data line: host release plus target pull-down
  assign sda_line = sda_drv & ~(i2c_sda_oe & ~i2c_sda_out);

  pmi_command_decoder #(.RESET_DELAY_CYCLES(DELAY)) DUT (
    .clock, .reset_n, .link_clock, .i2c_scl, .i2c_sda_in(sda_line), .i2c_sda_out,
    .i2c_sda_oe, .core_switcher_good, .status_in, .precore_linear_reg_en,
    .pll_linear_reg_en, .io_linear_reg_en, .memory_switcher_en, .core_switcher_en,
    .first_aux_reg_en, .second_aux_reg_en, .power_enable_pin_mask, .event_mask,
    .deep_sleep_ready, .deep_sleep_request, .deep_sleep_enter, .charger_enable,
    .first_aux_code, .second_aux_code, .voltage_program_code, .processor_reset_n);

  pmi_host_model host (.scl(i2c_scl), .sda_drv(sda_drv), .sda_line(sda_line));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task conclude();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // settle past the edge so the design's updates have landed
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // write address plus one or two command bytes, every byte acked
  task wr(input logic [7:0] b1, input logic [7:0] b2, input logic two);
    logic k0, k1, k2;
    host.start_c();
    host.send_byte(PMI_WRITE_ADDR, k0);
    host.send_byte(b1, k1);
    k2 = 1'b1;
    if (two)
      host.send_byte(b2, k2);
    host.stop_c();
    chk({5'h0, k0, k1, k2}, 8'h07);
    tick(20);
  endtask : wr

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    tick(5);
    @(posedge clock) reset_n <= 1'b1;
    tick(10);
    chk({precore_linear_reg_en, pll_linear_reg_en, io_linear_reg_en, memory_switcher_en,
      core_switcher_en, power_enable_pin_mask, first_aux_reg_en, second_aux_reg_en},
      {PMI_OUTPUT_EN_RESET, PMI_AUX_SLEEP_RESET[3], PMI_AUX_SLEEP_RESET[4]});
    chk({2'h0, event_mask}, {2'h0, PMI_EVENT_MASK_RESET});
    chk({deep_sleep_ready, deep_sleep_request, deep_sleep_enter, charger_enable,
      second_aux_code, first_aux_code}, {PMI_AUX_SLEEP_RESET[2:1], 1'b0,
      PMI_AUX_VOLT_RESET[0], PMI_AUX_VOLT_RESET[4:3], PMI_AUX_VOLT_RESET[2:1]});
    chk({3'h0, voltage_program_code}, {3'h0, PMI_CORE_CODE_RESET});
    $display("test defaults finished");
    // release timer, then a supply drop pulls reset back down
    @(posedge clock) core_switcher_good <= 1'b1;
    tick(DELAY - 1);
    chk({7'h0, processor_reset_n}, 8'h00);
    for (int i = 0; i < 30 && processor_reset_n !== 1'b1; i++)
      tick(1);
    chk({7'h0, processor_reset_n}, 8'h01);
    @(posedge clock) core_switcher_good <= 1'b0;
    tick(8);
    chk({7'h0, processor_reset_n}, 8'h00);
    @(posedge clock) core_switcher_good <= 1'b1;
    $display("test reset timer finished");
    foreach (codes[i])
    begin
      wr({PMI_GROUP_CORE, codes[i]}, 8'h00, 1'b0);
      chk({3'h0, voltage_program_code}, {3'h0, codes[i]});
    end
    for (int i = 0; i < 4; i++)
    begin
      v = 2'(i);
      wr({PMI_GROUP_AUX_VOLT, v, ~v, v[0]}, 8'h00, 1'b0);
      chk({3'h0, second_aux_code, first_aux_code, charger_enable}, {3'h0, v, ~v, v[0]});
    end
    wr({PMI_GROUP_AUX_SLEEP, 5'h09}, 8'h00, 1'b0);
    chk({4'h0, second_aux_reg_en, first_aux_reg_en, deep_sleep_ready, deep_sleep_request},
      8'h04);
    foreach (sleeps[i])
    begin
      wr({PMI_GROUP_AUX_SLEEP, sleeps[i]}, 8'h00, 1'b0);
      chk({5'h0, deep_sleep_enter, core_switcher_en, precore_linear_reg_en},
        (i == 2) ? 8'h04 : 8'h03);
    end
    $display("test single commands finished");
    wr({PMI_GROUP_PAIR, 5'h00}, {PMI_SET_OUTPUT, 6'h15}, 1'b1);
    chk({2'h0, precore_linear_reg_en, pll_linear_reg_en, io_linear_reg_en,
      memory_switcher_en, core_switcher_en, power_enable_pin_mask}, 8'h15);
    wr({PMI_GROUP_PAIR, 5'h00}, 8'hc0, 1'b1);
    chk({3'h0, pll_linear_reg_en, core_switcher_en, power_enable_pin_mask, 2'h0},
      8'h14);
    foreach (masks[i])
    begin
      wr({PMI_GROUP_PAIR, 5'h00}, {PMI_SET_MASK, masks[i]}, 1'b1);
      chk({2'h0, event_mask}, {2'h0, masks[i] | 6'h04});
    end
    wr({PMI_GROUP_PAIR, 5'h00}, {PMI_SET_OUTPUT, 6'h3e}, 1'b1);
    $display("test command pairs finished");
    @(posedge clock) status_in <= 8'ha5;
    host.start_c();
    host.send_byte(PMI_READ_ADDR, a0);
    host.read_byte(1'b1, rd);
    host.stop_c();
    chk({7'h0, a0}, 8'h01);
    chk(rd, 8'ha5);
    host.start_c();
    host.send_byte(8'h9e, a0);
    host.send_byte({PMI_GROUP_CORE, 5'h01}, a1);
    host.stop_c();
    tick(20);
    chk({6'h0, a0, a1}, 8'h00);
    chk({3'h0, voltage_program_code}, 8'h08);
    wr({PMI_GROUP_CORE, 5'h12}, 8'h00, 1'b0);
    chk({3'h0, voltage_program_code}, 8'h12);
    $display("test read and foreign address finished");
    conclude();
  end
endmodule : pmic_i2c_command_decoder_bench
